// file: spls_pkg.sv
// Constants for the serial-loaded frequency synthesizer core.
// Assumes one 125 MHz system clock and AXI4-Lite register access.
package spls_pkg;
    // Divide word layout
    localparam int SHIFT_W = 17;
    localparam int SWAL_W  = 7;
    localparam int PROG_W  = 10;
    localparam int SWAL_LSB = 0;
    localparam int PROG_LSB = 7;
    localparam logic [16:0] LATCH_RST = 17'h0_0000;

    // Reference divider
    localparam int REF_W = 11;
    localparam int REF_SEL_W = 3;

    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] LATCH_OFS  = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    // Control register fields
    localparam int CTRL_PUMP_EN  = 0;
    localparam int CTRL_PHASE_EN = 1;
    localparam logic [1:0] CTRL_RST = 2'h3;

    // Status register fields
    localparam int STAT_LOCK    = 0;
    localparam int STAT_UP      = 1;
    localparam int STAT_DOWN    = 2;
    localparam int STAT_MOD     = 3;
    localparam int STAT_SEL_LSB = 4;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin synchroniser depth
    localparam int SYNC_STAGES = 3;

    // Phase detector states
    typedef enum logic [2:0] {
        PFD_IDLE = 3'b001,
        PFD_UP   = 3'b010,
        PFD_DOWN = 3'b100
    } spls_pfd_type;
endpackage

// file: spls_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes inputs are asynchronous to aclk.
`timescale 1ns/10ps
module spls_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] lvl_q;
    logic [WIDTH-1:0] lvl_d;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // Counted only once stages two and three agree
            assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q  <= pin;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;
    assign rise  = lvl_d & ~lvl_q;
    assign fall  = ~lvl_d & lvl_q;
endmodule

// file: spls_core.sv
// Serial-loaded dual-modulus frequency synthesizer digital core.
// Assumes pins are asynchronous; registers reached over AXI4-Lite.
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module spls_core (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    serial_clk,
    input  wire logic                    serial_data,
    input  wire logic                    load_strobe,
    input  wire logic                    div_in,
    input  wire logic                    osc_in,
    input  wire logic                    ref_ratio_sel_a,
    input  wire logic                    ref_ratio_sel_b,
    input  wire logic                    ref_ratio_sel_c,
    output logic                         dual_ratio_sel,
    output logic                         lock_flag,
    output logic                         pump_out,
    output logic                         pump_oe,
    output logic                         phase_ref_n,
    output logic                         phase_div_n
);
    // Reference terminal count for a select code
    function automatic logic [10:0] ref_last(input logic [2:0] sel);
        logic [10:0] r;
        r = 11'h007;
        case (sel)
            3'h0:    r = 11'h007;
            3'h1:    r = 11'h00F;
            3'h2:    r = 11'h03F;
            3'h3:    r = 11'h07F;
            3'h4:    r = 11'h0FF;
            3'h5:    r = 11'h1FF;
            3'h6:    r = 11'h3FF;
            default: r = 11'h7FF;
        endcase
        return r;
    endfunction

    // Synchronised pins
    logic [7:0] pin_vec;
    logic [7:0] pin_lvl;
    logic [7:0] pin_rise;
    logic [7:0] pin_fall;

    assign pin_vec = {ref_ratio_sel_c, ref_ratio_sel_b, ref_ratio_sel_a,
                      osc_in, div_in, load_strobe, serial_data, serial_clk};

    spls_pin_sync #(
        .WIDTH (8)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (pin_vec),
        .level   (pin_lvl),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    wire       sclk_rise  = pin_rise[0];
    wire       sdata_lvl  = pin_lvl[1];
    wire       load_lvl   = pin_lvl[2];
    wire       div_fall   = pin_fall[3];
    wire       osc_rise   = pin_rise[4];
    wire [2:0] ratio_sel  = pin_lvl[7:5];

    // Serial shift register and latch
    logic [spls_pkg::SHIFT_W-1:0] shift_q;
    logic [spls_pkg::SHIFT_W-1:0] shift_d;
    logic [spls_pkg::SHIFT_W-1:0] latch_q;
    logic [spls_pkg::SHIFT_W-1:0] latch_d;

    // Earliest bit ends up on top, so a MSB-first word lands in place
    assign shift_d = sclk_rise ? {shift_q[15:0], sdata_lvl} : shift_q;
    // Transparent while the strobe is high; the shift is seen as it changes
    assign latch_d = load_lvl ? shift_q : latch_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_q <= '0;
            latch_q <= spls_pkg::LATCH_RST;
        end else begin
            shift_q <= shift_d;
            latch_q <= latch_d;
        end
    end

    // Divide factors straight from the latch
    wire [spls_pkg::SWAL_W-1:0] swal_set = latch_q[spls_pkg::SWAL_LSB +: spls_pkg::SWAL_W];
    wire [spls_pkg::PROG_W-1:0] prog_set = latch_q[spls_pkg::PROG_LSB +: spls_pkg::PROG_W];

    // Pulse-swallow divider
    logic [spls_pkg::SWAL_W-1:0] swal_q;
    logic [spls_pkg::SWAL_W-1:0] swal_d;
    logic [spls_pkg::PROG_W-1:0] prog_q;
    logic [spls_pkg::PROG_W-1:0] prog_d;
    logic                        mod_q;
    logic                        mod_d;
    logic                        fp_q;
    logic                        fp_d;

    // Factors below two wrap every period; the controller keeps N at 5 or more
    wire prog_end = (prog_q <= 10'h001);
    wire swal_run = (swal_q != 7'h00);

    always_comb begin
        swal_d = swal_q;
        prog_d = prog_q;
        mod_d  = mod_q;
        fp_d   = 1'b0;
        if (div_fall) begin
            if (prog_end) begin
                // Reload both counters from the latch each divided period
                prog_d = prog_set;
                swal_d = swal_set;
                fp_d   = 1'b1;
            end else begin
                prog_d = prog_q - 10'h001;
                if (swal_run) begin
                    swal_d = swal_q - 7'h01;
                end
            end
            // Low while swallowing, giving N*M+A total periods
            mod_d = (swal_d == 7'h00);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swal_q <= '0;
            prog_q <= '0;
            mod_q  <= 1'b1;
            fp_q   <= 1'b0;
        end else begin
            swal_q <= swal_d;
            prog_q <= prog_d;
            mod_q  <= mod_d;
            fp_q   <= fp_d;
        end
    end

    // Reference divider
    logic [spls_pkg::REF_W-1:0] ref_q;
    logic [spls_pkg::REF_W-1:0] ref_d;
    logic                       fr_q;
    logic                       fr_d;

    wire [spls_pkg::REF_W-1:0] ref_top = ref_last(ratio_sel);
    wire                       ref_end = (ref_q >= ref_top);

    always_comb begin
        ref_d = ref_q;
        fr_d  = 1'b0;
        if (osc_rise) begin
            // A ratio change mid-count finishes early rather than overrun
            if (ref_end) begin
                ref_d = '0;
                fr_d  = 1'b1;
            end else begin
                ref_d = ref_q + 11'h001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_q <= '0;
            fr_q  <= 1'b0;
        end else begin
            ref_q <= ref_d;
            fr_q  <= fr_d;
        end
    end

    // Phase-frequency detector
    spls_pkg::spls_pfd_type pfd_q;
    spls_pkg::spls_pfd_type pfd_d;

    always_comb begin
        pfd_d = pfd_q;
        case (pfd_q)
            spls_pkg::PFD_IDLE: begin
                if (fr_q && !fp_q) begin
                    pfd_d = spls_pkg::PFD_UP;
                end else if (fp_q && !fr_q) begin
                    pfd_d = spls_pkg::PFD_DOWN;
                end
            end
            spls_pkg::PFD_UP: begin
                if (fp_q) begin
                    pfd_d = spls_pkg::PFD_IDLE;
                end
            end
            spls_pkg::PFD_DOWN: begin
                if (fr_q) begin
                    pfd_d = spls_pkg::PFD_IDLE;
                end
            end
            default: pfd_d = spls_pkg::PFD_IDLE;
        endcase
    end

    // Control register
    logic [1:0] ctrl_q;
    logic [1:0] ctrl_d;

    wire pump_en  = ctrl_q[spls_pkg::CTRL_PUMP_EN];
    wire phase_en = ctrl_q[spls_pkg::CTRL_PHASE_EN];
    wire pfd_up   = (pfd_d == spls_pkg::PFD_UP);
    wire pfd_dn   = (pfd_d == spls_pkg::PFD_DOWN);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pfd_q          <= spls_pkg::PFD_IDLE;
            dual_ratio_sel <= 1'b1;
            lock_flag      <= 1'b1;
            pump_out       <= 1'b0;
            pump_oe        <= 1'b0;
            phase_ref_n    <= 1'b1;
            phase_div_n    <= 1'b1;
        end else begin
            pfd_q          <= pfd_d;
            dual_ratio_sel <= mod_d;
            lock_flag      <= !(pfd_up || pfd_dn);
            pump_out       <= pfd_up;
            pump_oe        <= pump_en && (pfd_up || pfd_dn);
            phase_ref_n    <= !(phase_en && pfd_up);
            phase_div_n    <= !(phase_en && pfd_dn);
        end
    end

    // AXI4-Lite write channel
    logic        have_aw_q;
    logic        have_w_q;
    logic [7:0]  waddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    wire aw_take   = s_axi_awvalid && s_axi_awready;
    wire w_take    = s_axi_wvalid && s_axi_wready;
    wire b_done    = s_axi_bvalid && s_axi_bready;
    wire have_aw_n = have_aw_q || aw_take;
    wire have_w_n  = have_w_q || w_take;
    wire do_write  = have_aw_n && have_w_n && !s_axi_bvalid;

    wire [7:0]  wa_cur = have_aw_q ? waddr_q : s_axi_awaddr;
    wire [31:0] wd_cur = have_w_q ? wdata_q : s_axi_wdata;
    wire [3:0]  ws_cur = have_w_q ? wstrb_q : s_axi_wstrb;
    wire        wr_ctrl = (wa_cur == spls_pkg::CTRL_OFS);
    wire        wr_ok   = wr_ctrl || (wa_cur == spls_pkg::LATCH_OFS)
                          || (wa_cur == spls_pkg::STATUS_OFS);
    wire        bvalid_n = do_write || (s_axi_bvalid && !s_axi_bready);

    assign ctrl_d = (do_write && wr_ctrl && ws_cur[0]) ? wd_cur[1:0] : ctrl_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw_q     <= 1'b0;
            have_w_q      <= 1'b0;
            waddr_q       <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
            ctrl_q        <= spls_pkg::CTRL_RST;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= spls_pkg::RESP_OKAY;
        end else begin
            have_aw_q     <= have_aw_n && !do_write;
            have_w_q      <= have_w_n && !do_write;
            waddr_q       <= aw_take ? s_axi_awaddr : waddr_q;
            wdata_q       <= w_take ? s_axi_wdata : wdata_q;
            wstrb_q       <= w_take ? s_axi_wstrb : wstrb_q;
            ctrl_q        <= ctrl_d;
            // One write in flight; ready drops once a half is held
            s_axi_awready <= !(have_aw_n && !do_write) && !bvalid_n;
            s_axi_wready  <= !(have_w_n && !do_write) && !bvalid_n;
            s_axi_bvalid  <= bvalid_n;
            if (do_write) begin
                s_axi_bresp <= wr_ok ? spls_pkg::RESP_OKAY : spls_pkg::RESP_SLVERR;
            end else if (b_done) begin
                s_axi_bresp <= spls_pkg::RESP_OKAY;
            end
        end
    end

    // AXI4-Lite read channel
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire r_done  = s_axi_rvalid && s_axi_rready;
    wire rd_ctrl = (s_axi_araddr == spls_pkg::CTRL_OFS);
    wire rd_lat  = (s_axi_araddr == spls_pkg::LATCH_OFS);
    wire rd_stat = (s_axi_araddr == spls_pkg::STATUS_OFS);

    logic [31:0] status_word;
    logic [31:0] rd_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[spls_pkg::STAT_LOCK] = lock_flag;
        status_word[spls_pkg::STAT_UP]   = (pfd_q == spls_pkg::PFD_UP);
        status_word[spls_pkg::STAT_DOWN] = (pfd_q == spls_pkg::PFD_DOWN);
        status_word[spls_pkg::STAT_MOD]  = dual_ratio_sel;
        status_word[spls_pkg::STAT_SEL_LSB +: spls_pkg::REF_SEL_W] = ratio_sel;
    end

    assign rd_word = rd_ctrl ? {30'h0000_0000, ctrl_q}
                   : rd_lat  ? {15'h0000, latch_q}
                   : rd_stat ? status_word
                   : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= spls_pkg::RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_rvalid  <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= (rd_ctrl || rd_lat || rd_stat) ? spls_pkg::RESP_OKAY
                                                                : spls_pkg::RESP_SLVERR;
            end else if (r_done) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// file: spls_core_asserts.sv
// Pin and bus checks for the synthesizer core.
// Assumes a bind onto spls_core; one aclk domain.
`timescale 1ns/10ps
module spls_core_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic div_in,
    input wire logic dual_ratio_sel,
    input wire logic lock_flag,
    input wire logic pump_out,
    input wire logic pump_oe,
    input wire logic phase_ref_n,
    input wire logic phase_div_n
);
    logic       div_q;
    logic [7:0] since_q;
    logic [7:0] since_d;

    // Saturates so a long idle input never wraps back into the window
    assign since_d = (div_q && !div_in) ? 8'h00 : since_q + {7'h00, since_q != 8'hff};

    always_ff @(posedge aclk) begin
        div_q   <= div_in;
        since_q <= aresetn ? since_d : 8'hff;
    end

    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_MOD_ON_FALL: assert property ($changed(dual_ratio_sel) |-> since_q < 8'h09)
        else $error("modulus select moved without a divider input fall");
    AST_UP_DRIVES: assert property (pump_oe && !phase_ref_n |-> pump_out)
        else $error("pump not driving while reference leads");
    AST_DOWN_SINKS: assert property (pump_oe && !phase_div_n |-> !pump_out)
        else $error("pump not sinking while divided rate leads");
    AST_PHASE_EXCL: assert property (phase_ref_n || phase_div_n)
        else $error("both phase outputs active");
    AST_LOCK_IDLE: assert property (lock_flag |-> phase_ref_n && phase_div_n && !pump_oe)
        else $error("lock flag high during phase error");
    AST_LOCK_LOW: assert property ($fell(phase_ref_n) || $fell(phase_div_n) |-> !lock_flag)
        else $error("lock flag not low when error starts");
    AST_RST_OUT: assert property ($rose(aresetn) |-> lock_flag && dual_ratio_sel && !pump_oe && s_axi_awready)
        else $error("outputs not at reset values after release");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not freed after response");
    AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write readies high while response pending");
    AST_AW_TAKE: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address ready not dropped after taking");
    AST_AR_TAKE: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one cycle after address");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not freed after data");
endmodule

// file: spls_ctrl_model.sv
// Behavioural controller loading divide words over the three-wire link.
// Assumes the core samples the link with its own clock; 160 ns link period.
`timescale 1ns/10ps
module spls_ctrl_model (
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    initial begin
        serial_clk  = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end

    // Link clock stands low between words
    task automatic load_word(input logic [16:0] word, input logic strobe);
        logic [16:0] w;
        w = word;
        #2; // Keeps pin changes off aclk edges
        if (w[16:7] < 10'h005) w[16:7] = 10'h005;
        for (int i = 16; i >= 0; i--) begin
            serial_data = w[i];
            #80;
            serial_clk = 1'b1;
            #80;
            serial_clk = 1'b0;
        end
        #80;
        serial_data = ~w[0]; // No pull on the line, so no stale value
        load_strobe = strobe;
        #80;
        load_strobe = 1'b0;
    endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the synthesizer core.
// Assumes spls_pkg, spls_core and the controller model are compiled first.
`timescale 1ns/10ps
module tb_top;
    localparam logic [31:0] RATIO [8] = '{32'h0000_0008, 32'h0000_0010, 32'h0000_0040, 32'h0000_0080,
                                          32'h0000_0100, 32'h0000_0200, 32'h0000_0400, 32'h0000_0800};
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        serial_clk, serial_data, load_strobe, div_in, osc_in;
    logic        ref_ratio_sel_a, ref_ratio_sel_b, ref_ratio_sel_c;
    logic        dual_ratio_sel, lock_flag, pump_out, pump_oe, phase_ref_n, phase_div_n;
    int          num_errors, checks_done, cycles, lows, n;
    wire [4:0]   pd_pins = {lock_flag, pump_oe, pump_out, phase_ref_n, phase_div_n};

    spls_core spls_core_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .serial_clk(serial_clk), .serial_data(serial_data),
        .load_strobe(load_strobe), .div_in(div_in), .osc_in(osc_in), .ref_ratio_sel_a(ref_ratio_sel_a),
        .ref_ratio_sel_b(ref_ratio_sel_b), .ref_ratio_sel_c(ref_ratio_sel_c), .dual_ratio_sel(dual_ratio_sel),
        .lock_flag(lock_flag), .pump_out(pump_out), .pump_oe(pump_oe), .phase_ref_n(phase_ref_n),
        .phase_div_n(phase_div_n));

    spls_ctrl_model spls_ctrl_model_i (.serial_clk(serial_clk), .serial_data(serial_data),
        .load_strobe(load_strobe));

    always #4 aclk = ~aclk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Ceiling well above the ~45k cycles the tests need
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    // Ready signals drop once a half is held and return after the response, so each valid waits for its own ready
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er, input string what);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        check({30'h0, s_axi_bresp}, {30'h0, er}, what);
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, exp, what);
        check({30'h0, s_axi_rresp}, {30'h0, er}, what);
    endtask

    // Samples the modulus select just before each divider input fall
    task automatic run_div(input int falls);
        lows = 0;
        repeat (falls) begin
            repeat (16) @(posedge aclk);
            div_in <= 1'b1;
            repeat (16) @(posedge aclk);
            if (dual_ratio_sel !== 1'b1) lows++;
            div_in <= 1'b0;
        end
    endtask

    task automatic load(input logic [16:0] w, input logic strobe);
        spls_ctrl_model_i.load_word(w, strobe);
        @(posedge aclk);
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, div_in, osc_in} = 5'h00;
        {s_axi_bready, s_axi_rready} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {ref_ratio_sel_c, ref_ratio_sel_b, ref_ratio_sel_a} = 3'h0;
        do_reset();
        rd_chk(spls_pkg::CTRL_OFS, 32'h0000_0003, spls_pkg::RESP_OKAY, "ctrl reset");
        rd_chk(spls_pkg::LATCH_OFS, 32'h0000_0000, spls_pkg::RESP_OKAY, "latch reset");
        rd_chk(8'h0c, 32'h0000_0000, spls_pkg::RESP_SLVERR, "unmapped read");
        wr_chk(8'h0c, 32'h0000_0001, spls_pkg::RESP_SLVERR, "unmapped write");
        wr_chk(spls_pkg::LATCH_OFS, 32'h0001_ffff, spls_pkg::RESP_OKAY, "latch write");
        rd_chk(spls_pkg::LATCH_OFS, 32'h0000_0000, spls_pkg::RESP_OKAY, "latch read only");
        $display("test registers done");
        load({10'h3a5, 7'h55}, 1'b0);
        rd_chk(spls_pkg::LATCH_OFS, 32'h0000_0000, spls_pkg::RESP_OKAY, "latch without strobe");
        load({10'h005, 7'h02}, 1'b1);
        rd_chk(spls_pkg::LATCH_OFS, 32'h0000_0282, spls_pkg::RESP_OKAY, "latch word");
        $display("test serial load done");
        run_div(20);
        run_div(15);
        check(32'(lows), 32'h0000_0006, "swallow low periods");
        check({27'h0, pd_pins}, 32'h0000_000a, "sink");
        load({10'h005, 7'h00}, 1'b1);
        run_div(20);
        run_div(15);
        check(32'(lows), 32'h0000_0000, "no swallow");
        $display("test divider done");
        for (int c = 0; c < 8; c++) begin
            {ref_ratio_sel_c, ref_ratio_sel_b, ref_ratio_sel_a} <= 3'(c);
            do_reset();
            n = 0;
            while (pump_oe !== 1'b1 && n < 2100) begin
                osc_in <= 1'b1;
                repeat (5) @(posedge aclk);
                osc_in <= 1'b0;
                repeat (5) @(posedge aclk);
                n++;
            end
            check(32'(n), RATIO[c], "reference ratio");
        end
        check({27'h0, pd_pins}, 32'h0000_000d, "drive");
        rd_chk(spls_pkg::STATUS_OFS, 32'h0000_007a, spls_pkg::RESP_OKAY, "status up");
        $display("test reference done");
        wr_chk(spls_pkg::CTRL_OFS, 32'h0000_0000, spls_pkg::RESP_OKAY, "ctrl clear");
        repeat (2) @(posedge aclk);
        check({30'h0, pump_oe, phase_ref_n}, 32'h0000_0001, "outputs gated off");
        rd_chk(spls_pkg::CTRL_OFS, 32'h0000_0000, spls_pkg::RESP_OKAY, "ctrl readback");
        wr_chk(spls_pkg::CTRL_OFS, 32'h0000_0003, spls_pkg::RESP_OKAY, "ctrl set");
        repeat (2) @(posedge aclk);
        check({30'h0, pump_oe, pump_out}, 32'h0000_0003, "pump drives again");
        load({10'h005, 7'h00}, 1'b1);
        run_div(1);
        repeat (8) @(posedge aclk);
        check({27'h0, pd_pins}, 32'h0000_0013, "locked again");
        $display("test control done");
        summarize();
    end
endmodule

bind spls_core spls_core_asserts spls_core_asserts_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .div_in(div_in), .dual_ratio_sel(dual_ratio_sel), .lock_flag(lock_flag), .pump_out(pump_out),
    .pump_oe(pump_oe), .phase_ref_n(phase_ref_n), .phase_div_n(phase_div_n));
